// ===== hw/vof_formatter.v
// What this block does
// [R01] Format field 10 selects event-code stream
// [R02] Format 00 gives separate luma/chroma ports
// [R03] Event: chroma phase FE/FF then luma
// [R04] Luma 01 after last active pixel
// [R05] Luma 02 before first active pixel
// [R06] Horizontal edge inserts 03 active, 04 blank
// [R07] Vertical falling edge inserts 05 or 06
// [R08] Horizontal level low odd, high even
// [R09] Active codes and data only on active lines
// [R10] Host enables qualifier in blanking window
// [R11] Programmable qualifier start/end from registers
// [R12] Data delays readable per window
// [R13] Horizontal code deferred until after end code
// [R14] Limit data off 0, 1, 254, 255
// [R15] Shuffle swaps ports or luma/chroma order
// [R16] Normal mode 16-bit at pixel clock
// [R17] Double rate order Cb, Y, Cr, Y
// [R18] 8-bit uses first port; second static
// [R19] Tristate by pin or register
// [R20] Line leaves as one burst; drop by qualifier
// [R21] Doubled line-locked clock output
// [R22] Half clock gates every second pulse
// [R23] Horizontal inactive phase exactly 64 clocks
`timescale 1ns/10ps
`default_nettype none
`include "vof_defs.vh"
module vof_formatter #(
	parameter DW = 8
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_link_clk,
	input wire [DW-1:0] i_luma,
	input wire [DW-1:0] i_chroma,
	input wire i_active,
	input wire i_line_active,
	input wire i_vbi_window,
	input wire i_horizontal_reference_in,
	input wire i_vref_in,
	input wire [11:0] i_hpos,
	input wire [11:0] i_dly1,
	input wire [11:0] i_dly2,
	input wire i_oe_n,
	input wire i_cfg_we,
	input wire [11:0] i_cfg_addr,
	input wire [11:0] i_cfg_wdata,
	output reg [11:0] o_cfg_rdata,
	output reg [DW-1:0] o_port_a,
	output wire o_port_a_oe,
	output reg [DW-1:0] o_port_b,
	output wire o_port_b_oe,
	output reg o_valid_video_qualifier,
	output reg o_horizontal_reference,
	output reg o_vertical_reference,
	output reg o_pixel_transfer_clock,
	output reg o_line_locked_double_clock
);
	////////////////////////////////////////////////////////////////
	reg [11:0] std_sel, vbiq, tmode, fmt, qstart, qend, pol, mux;
	reg [7:0] tri_ctl;
	always @(posedge i_clk) begin
		if (i_rst) begin
			std_sel <= `VOF_RST12;
			vbiq <= `VOF_RST12;
			tmode <= `VOF_RST12;
			fmt <= `VOF_RST12;
			qstart <= `VOF_RST12;
			qend <= `VOF_RST12;
			pol <= `VOF_RST12;
			mux <= `VOF_RST12;
			tri_ctl <= `VOF_RST8;
		end else if (i_cfg_we) begin
			if (i_cfg_addr == `VOF_REG_STD) std_sel <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_VBIQ) vbiq <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_TMODE) tmode <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_FMT) fmt <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_QSTART) qstart <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_QEND) qend <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_POL) pol <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_MUX) mux <= i_cfg_wdata;
			else if (i_cfg_addr == `VOF_REG_TRI) tri_ctl <= i_cfg_wdata[7:0];
		end
	end
	// Read data registered; unmapped addresses read zero
	always @(posedge i_clk) begin
		if (i_rst) o_cfg_rdata <= `VOF_RST12;
		else if (i_cfg_addr == `VOF_REG_STD) o_cfg_rdata <= std_sel;
		else if (i_cfg_addr == `VOF_REG_DLY1) o_cfg_rdata <= i_dly1; // [R12]
		else if (i_cfg_addr == `VOF_REG_DLY2) o_cfg_rdata <= i_dly2; // [R12]
		else if (i_cfg_addr == `VOF_REG_VBIQ) o_cfg_rdata <= vbiq;
		else if (i_cfg_addr == `VOF_REG_TMODE) o_cfg_rdata <= tmode;
		else if (i_cfg_addr == `VOF_REG_FMT) o_cfg_rdata <= fmt;
		else if (i_cfg_addr == `VOF_REG_QSTART) o_cfg_rdata <= qstart;
		else if (i_cfg_addr == `VOF_REG_QEND) o_cfg_rdata <= qend;
		else if (i_cfg_addr == `VOF_REG_POL) o_cfg_rdata <= pol;
		else if (i_cfg_addr == `VOF_REG_MUX) o_cfg_rdata <= mux;
		else if (i_cfg_addr == `VOF_REG_TRI) o_cfg_rdata <= {4'h0, tri_ctl};
		else o_cfg_rdata <= `VOF_RST12;
	end
	////////////////////////////////////////////////////////////////
	// Link clock and output enable pin synchronisers
	reg lk_s1, lk_s2, lk_s3, oe_s1, oe_s2;
	always @(posedge i_clk) begin
		if (i_rst) begin
			lk_s1 <= 1'b0;
			lk_s2 <= 1'b0;
			lk_s3 <= 1'b0;
			oe_s1 <= 1'b1;
			oe_s2 <= 1'b1;
		end else begin
			lk_s1 <= i_link_clk;
			lk_s2 <= lk_s1;
			lk_s3 <= lk_s2;
			oe_s1 <= i_oe_n;
			oe_s2 <= oe_s1;
		end
	end
	// Doubled clock edge: each link clock edge is one transport slot
	wire slot = lk_s2 ^ lk_s3;
	wire pix_edge = lk_s2 & ~lk_s3;
	////////////////////////////////////////////////////////////////
	wire [1:0] fmt_sel = fmt[`VOF_FMT_HI:`VOF_FMT_LO];
	wire evt_mode = (fmt_sel == `VOF_FMT_EVT); // [R01]
	wire sep_mode = (fmt_sel == `VOF_FMT_SEP); // [R02]
	wire shuffle = fmt[`VOF_FMT_SHUF];
	wire half_clk = fmt[`VOF_FMT_HALF] & sep_mode; // [R22]
	wire dbl = mux[`VOF_MUX_DBL] | evt_mode;
	wire prog_q = tmode[`VOF_TM_PROGQ];
	wire vbi_ok = ~i_vbi_window | vbiq[`VOF_VBIQ_EN]; // [R10]
	// Qualifier: programmable window or upstream valid flag
	wire q_prog = (i_hpos >= qstart) && (i_hpos < qend); // [R11]
	wire q_raw = (prog_q ? q_prog : i_active) & i_line_active & vbi_ok; // [R09] [R20]
	////////////////////////////////////////////////////////////////
	// Horizontal reference: inactive phase of fixed length
	reg [9:0] hcnt;
	reg h_int, h_d, v_d, q_d, half_ph, phase;
	always @(posedge i_clk) begin
		if (i_rst) begin
			hcnt <= 10'd0;
			h_int <= 1'b0;
			h_d <= 1'b0;
			v_d <= 1'b0;
			q_d <= 1'b0;
			half_ph <= 1'b0;
			phase <= 1'b0;
		end else if (pix_edge) begin
			if (h_int && !i_horizontal_reference_in) begin
				h_int <= 1'b0;
				hcnt <= 10'd0;
			end else if (!h_int) begin
				hcnt <= hcnt + 10'd1;
				if (hcnt == `VOF_HINACT - 10'd1) h_int <= 1'b1; // [R23]
			end
			h_d <= h_int;
			v_d <= i_vref_in;
			q_d <= q_raw;
			half_ph <= ~half_ph;
			phase <= q_raw ? ~phase : 1'b0;
		end
	end
	wire h_rise = h_int & ~h_d;
	wire v_fall = v_d & ~i_vref_in;
	wire q_rise = q_raw & ~q_d;
	wire q_fall = ~q_raw & q_d;
	////////////////////////////////////////////////////////////////
	// Event sequencer: pending flags, end code beats deferred horizontal
	localparam S_DATA = 2'd0, S_CHR = 2'd1, S_LUM = 2'd2;
	reg [1:0] st;
	reg [7:0] ev_code;
	reg pend_h, pend_v, pend_s, pend_e, h_kind, v_kind;
	reg y_slot;
	always @(posedge i_clk) begin
		if (i_rst) begin
			st <= S_DATA;
			ev_code <= 8'h00;
			pend_h <= 1'b0;
			pend_v <= 1'b0;
			pend_s <= 1'b0;
			pend_e <= 1'b0;
			h_kind <= 1'b0;
			v_kind <= 1'b0;
			y_slot <= 1'b0;
		end else begin
			if (slot) begin
				y_slot <= ~y_slot;
				case (st)
				S_DATA: begin
					if (evt_mode && (pend_e || pend_s || pend_v || (pend_h && !q_raw))) begin
						st <= S_CHR;
					end
				end
				S_CHR: begin
					// Code is chosen here so it is ready when the luma slot goes out
					st <= S_LUM; // [R03]
					if (pend_e) begin
						ev_code <= `VOF_L_END; // [R04]
						pend_e <= 1'b0;
					end else if (pend_s) begin
						ev_code <= `VOF_L_START; // [R05]
						pend_s <= 1'b0;
					end else if (pend_h && !q_raw) begin
						ev_code <= h_kind ? `VOF_L_HACT : `VOF_L_HBLK; // [R06] [R13]
						pend_h <= 1'b0;
					end else if (pend_v) begin
						ev_code <= v_kind ? `VOF_L_VEVEN : `VOF_L_VODD; // [R07]
						pend_v <= 1'b0;
					end
				end
				S_LUM: st <= S_DATA;
				default: st <= S_DATA;
				endcase
			end
			// Sets follow the clears so an event landing on its emit slot is kept
			if (pix_edge && h_rise) begin
				pend_h <= 1'b1;
				h_kind <= i_line_active;
			end
			if (pix_edge && v_fall) begin
				pend_v <= 1'b1;
				v_kind <= h_int; // [R08]
			end
			if (pix_edge && q_rise) pend_s <= 1'b1;
			if (pix_edge && q_fall) pend_e <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	// Limiting keeps reserved identification words out of data
	function [7:0] lim;
		input [7:0] d;
		begin
			if (d < `VOF_LIM_LO) lim = `VOF_LIM_LO;
			else if (d > `VOF_LIM_HI) lim = `VOF_LIM_HI;
			else lim = d;
		end
	endfunction
	wire [7:0] y_v = evt_mode ? lim(i_luma) : i_luma; // [R14]
	wire [7:0] c_v = evt_mode ? lim(i_chroma) : i_chroma; // [R14]
	wire y_first = shuffle; // [R15]
	wire [7:0] mux8 = (y_slot ^ y_first) ? y_v : c_v; // [R17]
	wire [7:0] chr_code = phase ? `VOF_C_CR : `VOF_C_CB; // [R03]
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_port_a <= 8'h00;
			o_port_b <= 8'h00;
			o_valid_video_qualifier <= 1'b0;
			o_horizontal_reference <= 1'b0;
			o_vertical_reference <= 1'b0;
			o_pixel_transfer_clock <= 1'b0;
			o_line_locked_double_clock <= 1'b0;
		end else begin
			o_line_locked_double_clock <= lk_s2; // [R21]
			o_pixel_transfer_clock <= half_clk ? (lk_s2 & half_ph) : lk_s2; // [R22]
			o_horizontal_reference <= h_int ^ pol[`VOF_POL_H];
			o_vertical_reference <= i_vref_in ^ pol[`VOF_POL_V];
			o_valid_video_qualifier <= q_raw; // [R20]
			if (dbl) begin
				if (slot) begin
					if (st == S_CHR) o_port_a <= chr_code;
					else if (st == S_LUM) o_port_a <= ev_code;
					else o_port_a <= mux8; // [R17]
				end
				o_port_b <= mux[`VOF_MUX_STAT] ? mux[7:0] : 8'h00; // [R18]
			end else if (pix_edge) begin
				o_port_a <= shuffle ? c_v : y_v; // [R15] [R16]
				o_port_b <= shuffle ? y_v : c_v;
			end
		end
	end
	wire tri_all = oe_s2 | tri_ctl[`VOF_TRI_BIT]; // [R19]
	assign o_port_a_oe = ~tri_all;
	assign o_port_b_oe = ~tri_all & (~dbl | mux[`VOF_MUX_STAT]); // [R18]
endmodule
`default_nettype wire

// ===== include/vof_defs.vh
`ifndef VOF_DEFS_VH
`define VOF_DEFS_VH
// Register offsets of the processor configuration memory
`define VOF_REG_STD 12'h020
`define VOF_REG_DLY1 12'h10F
`define VOF_REG_DLY2 12'h11F
`define VOF_REG_VBIQ 12'h138
`define VOF_REG_TMODE 12'h140
`define VOF_REG_FMT 12'h150
`define VOF_REG_QSTART 12'h151
`define VOF_REG_QEND 12'h152
`define VOF_REG_POL 12'h153
`define VOF_REG_MUX 12'h154
`define VOF_REG_TRI 12'h0F2
// Field positions
`define VOF_FMT_LO 0
`define VOF_FMT_HI 1
`define VOF_FMT_SHUF 4
`define VOF_FMT_HALF 5
`define VOF_TM_PROGQ 2
`define VOF_VBIQ_EN 2
`define VOF_MUX_STAT 8
`define VOF_MUX_DBL 9
`define VOF_TRI_BIT 0
`define VOF_POL_H 0
`define VOF_POL_V 1
// Format codes
`define VOF_FMT_SEP 2'h0
`define VOF_FMT_EVT 2'h2
// Event codes
`define VOF_C_CR 8'hFE
`define VOF_C_CB 8'hFF
`define VOF_L_END 8'h01
`define VOF_L_START 8'h02
`define VOF_L_HACT 8'h03
`define VOF_L_HBLK 8'h04
`define VOF_L_VEVEN 8'h05
`define VOF_L_VODD 8'h06
// Data limits in event mode
`define VOF_LIM_LO 8'h02
`define VOF_LIM_HI 8'hFD
// Reset values
`define VOF_RST12 12'h000
`define VOF_RST8 8'h00
// Inactive phase of horizontal reference in pixel clocks
`define VOF_HINACT 10'd64
`endif

// ===== verif/vof_formatter_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "vof_defs.vh"
module vof_formatter_checker #(
	parameter DW = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire logic i_oe_n,
	input wire logic i_cfg_we,
	input wire logic [11:0] i_cfg_addr,
	input wire logic [11:0] i_cfg_wdata,
	input wire logic [11:0] i_dly1,
	input wire logic [11:0] i_dly2,
	input wire logic [11:0] o_cfg_rdata,
	input wire logic [DW-1:0] o_port_b,
	input wire logic o_port_a_oe,
	input wire logic o_port_b_oe,
	input wire logic o_line_locked_double_clock
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic tri_q;
	logic [11:0] mux_q;
	// Shadow copies of two control words, so no hierarchical peeking is needed
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tri_q <= 1'b0;
			mux_q <= `VOF_RST12;
		end else begin
			if (i_cfg_we && i_cfg_addr == `VOF_REG_TRI) begin
				tri_q <= i_cfg_wdata[0];
			end
			if (i_cfg_we && i_cfg_addr == `VOF_REG_MUX) begin
				mux_q <= i_cfg_wdata;
			end
		end
	end
	a_oe_pin_off: assert property (i_oe_n [*4] |-> !o_port_a_oe && !o_port_b_oe)
		else $error("ports driven while enable pin inactive");
	a_tri_reg_off: assert property (tri_q |-> !o_port_a_oe && !o_port_b_oe)
		else $error("ports driven while tristate bit set");
	a_unmapped_zero: assert property (i_cfg_addr == 12'h001 |=> o_cfg_rdata == `VOF_RST12)
		else $error("unmapped address read not zero");
	a_delay1_read: assert property (i_cfg_addr == `VOF_REG_DLY1 |=> o_cfg_rdata == $past(i_dly1))
		else $error("first window delay misread");
	a_delay2_read: assert property (i_cfg_addr == `VOF_REG_DLY2 |=> o_cfg_rdata == $past(i_dly2))
		else $error("second window delay misread");
	a_fmt_read_back: assert property (i_cfg_we && i_cfg_addr == `VOF_REG_FMT ##1
		i_cfg_addr == `VOF_REG_FMT |=> o_cfg_rdata == $past(i_cfg_wdata, 2))
		else $error("format word not read back");
	a_static_port_b: assert property (mux_q[9] && mux_q[8] && $stable(mux_q)
		|-> o_port_b == mux_q[7:0])
		else $error("static port value wrong");
	a_port_b_idle: assert property (mux_q[9] && !mux_q[8] |-> !o_port_b_oe)
		else $error("second port driven in 8-bit mode");
	a_llc_follow: assert property ($rose(i_link_clk) |-> ##[1:6] $rose(o_line_locked_double_clock))
		else $error("doubled clock output not following link clock");
endmodule
bind vof_formatter vof_formatter_checker #(.DW(DW)) chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_link_clk(i_link_clk), .i_oe_n(i_oe_n), .i_cfg_we(i_cfg_we), .i_cfg_addr(i_cfg_addr),
	.i_cfg_wdata(i_cfg_wdata), .i_dly1(i_dly1), .i_dly2(i_dly2), .o_cfg_rdata(o_cfg_rdata),
	.o_port_b(o_port_b), .o_port_a_oe(o_port_a_oe), .o_port_b_oe(o_port_b_oe),
	.o_line_locked_double_clock(o_line_locked_double_clock));
`default_nettype wire

// ===== verif/vof_sink_model.sv
`timescale 1ns/10ps
`default_nettype none
module vof_sink_model (
	input wire logic i_clk,
	input wire logic i_llc,
	input wire logic [7:0] i_port,
	output logic [7:0] o_evt_chroma,
	output logic [7:0] o_evt_luma,
	output logic [7:0] o_evt_cnt,
	output logic [7:0] o_last
);
	logic llc_d = 1'b0;
	logic [4:0] age = 5'h00;
	initial begin
		o_evt_chroma = 8'h00;
		o_evt_luma = 8'h00;
		o_evt_cnt = 8'h00;
		o_last = 8'h00;
	end
	// Latch mid-slot: the port is registered and changes on the same clock cycle as each llc edge
	always @(posedge i_clk) begin
		llc_d <= i_llc;
		age <= (llc_d != i_llc) ? 5'h00 : age + 5'h01;
		if (age == 5'h0A) begin
			o_last <= i_port;
			if (o_last >= 8'hFE && i_port < 8'hFE) begin
				o_evt_chroma <= o_last;
				o_evt_luma <= i_port;
				o_evt_cnt <= o_evt_cnt + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/vof_formatter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "vof_defs.vh"
module vof_formatter_tb_top;
	logic clk = 0, rst = 1, lk = 0, we = 0, oe_n = 0, act = 0, lact = 1, horizontal_reference = 1, vref = 1;
	logic [7:0] y = 0, c = 0, pa, pb, ec, el, en, last;
	logic [11:0] addr = 0, wd = 0, d1 = 0, d2 = 0, rdata, r, m;
	logic pa_oe, pb_oe, vq, ho, vo, pclk, line_locked_double_clock;
	int failures = 0, total_checks = 0, seed = 66398, n, hcnt = 0;
	logic [11:0] offs [9] = '{`VOF_REG_STD, `VOF_REG_VBIQ, `VOF_REG_TMODE, `VOF_REG_FMT,
		`VOF_REG_QSTART, `VOF_REG_QEND, `VOF_REG_POL, `VOF_REG_MUX, `VOF_REG_TRI};
	vof_formatter uut (.i_clk(clk), .i_rst(rst), .i_link_clk(lk), .i_luma(y), .i_chroma(c),
		.i_active(act), .i_line_active(lact), .i_vbi_window(1'b0), .i_horizontal_reference_in(horizontal_reference),
		.i_vref_in(vref), .i_hpos(12'h000), .i_dly1(d1), .i_dly2(d2), .i_oe_n(oe_n),
		.i_cfg_we(we), .i_cfg_addr(addr), .i_cfg_wdata(wd), .o_cfg_rdata(rdata),
		.o_port_a(pa), .o_port_a_oe(pa_oe), .o_port_b(pb), .o_port_b_oe(pb_oe),
		.o_valid_video_qualifier(vq), .o_horizontal_reference(ho), .o_vertical_reference(vo),
		.o_pixel_transfer_clock(pclk), .o_line_locked_double_clock(line_locked_double_clock));
	vof_sink_model sink (.i_clk(clk), .i_llc(line_locked_double_clock), .i_port(pa), .o_evt_chroma(ec),
		.o_evt_luma(el), .o_evt_cnt(en), .o_last(last));
	initial forever #2 clk = ~clk;
	initial begin
		#37;
		forever #80 lk = ~lk;
	end
	// Length of the current low phase of the horizontal reference output
	always @(posedge clk) hcnt <= (ho === 1'b0) ? hcnt + 1 : 0;
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [11:0] d);
		we = 1;
		addr = a;
		wd = d;
		tick(1);
		we = 0;
		tick(1);
	endtask
	task automatic rd(input logic [11:0] a, output logic [11:0] d);
		addr = a;
		tick(2);
		d = rdata;
	endtask
	task automatic evt(input logic [7:0] code);
		logic [7:0] c0;
		c0 = en;
		for (n = 0; n < 4000 && en === c0; n++)
			tick(1);
		check("event chroma", {4'h0, ec[7:1], 1'b0}, 12'h0FE);
		check("event luma", {4'h0, el}, {4'h0, code});
	endtask
	task automatic conclude();
		if (failures == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		failures++;
		conclude();
	end
	initial begin
		tick(16);
		rst = 0;
		d1 = 12'($random(seed));
		d2 = 12'($random(seed));
		foreach (offs[i]) begin
			rd(offs[i], r);
			check("reset value", r, `VOF_RST12);
			// Keep the programmable qualifier off so no stray events get queued
			m = (offs[i] == `VOF_REG_TRI) ? 12'h0FF : (offs[i] == `VOF_REG_TMODE) ? 12'hFFB : 12'hFFF;
			r = 12'($random(seed)) & m;
			wr(offs[i], r);
			rd(offs[i], m);
			check("read back", m, r);
			wr(offs[i], `VOF_RST12);
		end
		rd(12'h001, r);
		check("unmapped", r, `VOF_RST12);
		rd(`VOF_REG_DLY1, r);
		check("delay one", r, d1);
		wr(`VOF_REG_DLY2, 12'h0A5);
		rd(`VOF_REG_DLY2, r);
		check("delay two", r, d2);
		for (int s = 0; s < 2; s++) begin
			y = 8'($random(seed));
			c = 8'($random(seed));
			wr(`VOF_REG_FMT, s ? 12'h010 : 12'h000);
			tick(200);
			check("port a", {4'h0, pa}, {4'h0, s ? c : y});
			check("port b", {4'h0, pb}, {4'h0, s ? y : c});
			check("drive", {10'h0, pa_oe, pb_oe}, 12'h003);
		end
		r = {4'h3, 8'($random(seed))};
		wr(`VOF_REG_MUX, r);
		tick(4);
		check("static b", {4'h0, pb}, {4'h0, r[7:0]});
		wr(`VOF_REG_MUX, 12'h200);
		check("b released", {11'h0, pb_oe}, 12'h000);
		wr(`VOF_REG_TRI, 12'h001);
		check("tristate reg", {10'h0, pa_oe, pb_oe}, 12'h000);
		wr(`VOF_REG_TRI, `VOF_RST12);
		oe_n = 1;
		tick(6);
		check("tristate pin", {11'h0, pa_oe}, 12'h000);
		oe_n = 0;
		wr(`VOF_REG_MUX, `VOF_RST12);
		wr(`VOF_REG_FMT, 12'h002);
		tick(200);
		horizontal_reference = 0;
		evt(`VOF_L_HACT);
		for (n = 0; n < 4000 && ho !== 1'b1; n++)
			tick(1);
		check("inactive span", {11'h0, (hcnt > 2500 && hcnt < 2640)}, 12'h001);
		vref = 0;
		evt(`VOF_L_HACT);
		evt(`VOF_L_VEVEN);
		y = 8'h00;
		c = 8'hFF;
		act = 1;
		evt(`VOF_L_START);
		tick(200);
		check("limited", {11'h0, (last == 8'h02 || last == 8'hFD)}, 12'h001);
		act = 0;
		evt(`VOF_L_END);
		lact = 0;
		horizontal_reference = 1;
		vref = 1;
		tick(200);
		horizontal_reference = 0;
		evt(`VOF_L_HBLK);
		vref = 0;
		evt(`VOF_L_VODD);
		conclude();
	end
endmodule
`default_nettype wire
